// ==== edm_pkg.sv ====
// Shared constants, types and bit/phase mapping functions for the phase mapper
package edm_pkg;

   // Symbol and slot timing
   localparam int EDM_CLK_NS   = 4;
   localparam int EDM_SYM_NS   = 1000;
   localparam int EDM_SYM_CYC  = (EDM_SYM_NS + EDM_CLK_NS - 1) / EDM_CLK_NS;
   localparam int EDM_SLOT_US  = 625;
   localparam int EDM_SLOT_SYM = (EDM_SLOT_US * 1000) / EDM_SYM_NS;
   localparam int EDM_CYC_W    = 8;
   localparam int EDM_SLOT_W   = 10;

   // Values after reset
   localparam logic [EDM_CYC_W-1:0]  EDM_CYC_RST   = 8'h00;
   localparam logic [EDM_SLOT_W-1:0] EDM_SLOT_RST  = 10'h000;
   localparam logic [2:0]            EDM_PHASE_RST = 3'h0;

   typedef enum logic [1:0] {EDM_BR, EDM_R2, EDM_R3} edm_rate_t;
   typedef enum logic [2:0] {EDM_ACC, EDM_HDR, EDM_GRD, EDM_SYN, EDM_PAY, EDM_TRL} edm_sect_t;

   typedef struct packed {
      logic      valid;
      edm_sect_t sect;
      edm_rate_t rate;
      logic [2:0] bits;
   } edm_tx_req_t;

   typedef struct packed {
      logic       valid;
      logic       psk;
      logic       fsk_bit;
      logic [1:0] nbits;
      logic [2:0] dphase;
      logic [2:0] phase;
   } edm_tx_sym_t;

   typedef struct packed {
      logic       valid;
      edm_sect_t  sect;
      edm_rate_t  rate;
      logic       fsk_bit;
      logic [2:0] dphase;
   } edm_rx_sym_t;

   typedef struct packed {
      logic       valid;
      logic [1:0] nbits;
      logic [2:0] bits;
   } edm_rx_bits_t;

   // Bits per symbol: multi-bit only inside an enhanced-rate payload
   function automatic logic [1:0] edm_nbits(input edm_sect_t sect, input edm_rate_t rate);
      if (sect != EDM_PAY) begin
         return 2'h1;
      end
      case (rate)
         EDM_R2:  return 2'h2;
         EDM_R3:  return 2'h3;
         default: return 2'h1;
      endcase
   endfunction

   // Bit group to phase change in 45 degree units, modulo eight
   function automatic logic [2:0] edm_map(input logic [1:0] nbits, input logic [2:0] bits);
      logic b1;
      b1 = bits[2] ^ bits[1];
      case (nbits)
         2'h2:    return {bits[1], bits[1] ^ bits[0], 1'b1};
         2'h3:    return {bits[2], b1, b1 ^ bits[0]};
         default: return 3'h0;
      endcase
   endfunction

   // Phase change back to the bit group
   function automatic logic [2:0] edm_demap(input logic [1:0] nbits, input logic [2:0] dph);
      case (nbits)
         2'h2:    return {1'b0, dph[2], dph[2] ^ dph[1]};
         2'h3:    return dph ^ {1'b0, dph[2:1]};
         default: return 3'h0;
      endcase
   endfunction

endpackage

// ==== edm_demap.sv ====
// Receive demapper: phase change or frequency bit back to data bits
`timescale 1ns/1ps
`default_nettype none
module edm_demap
   import edm_pkg::*;
(
   input  wire logic          clk_sys, // System clock
   input  wire logic          nrst,    // Synchronous reset, active low
   input  wire edm_rx_sym_t   rx_sym,  // Symbol from the front end
   output var  edm_rx_bits_t  rx_bits  // Recovered bits, registered
);
   import edm_pkg::*;

   wire logic [1:0] nb_w  = edm_nbits(rx_sym.sect, rx_sym.rate);
   wire logic [2:0] dat_w = (nb_w == 2'h1) ? {2'h0, rx_sym.fsk_bit}
                                           : edm_demap(nb_w, rx_sym.dphase);
   edm_rx_bits_t bits_nxt;

   always_comb begin
      bits_nxt.valid = rx_sym.valid;
      bits_nxt.nbits = nb_w;
      bits_nxt.bits  = dat_w;
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rx_bits <= '0;
      end else begin
         rx_bits <= bits_nxt;
      end
   end

   chk_rx_two_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
      rx_sym.valid && nb_w == 2'h2 && rx_sym.dphase == 3'h5 |=> rx_bits.bits == 3'h3 && rx_bits.nbits == 2'h2)
      else $error("two-bit demap of -135 degrees wrong");
   chk_rx_three_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
      rx_sym.valid && nb_w == 2'h3 && rx_sym.dphase == 3'h6 |=> rx_bits.bits == 3'h5)
      else $error("three-bit demap of -90 degrees wrong");
   chk_rx_one_bit: assert property (@(posedge clk_sys) disable iff (!nrst)
      rx_sym.valid && rx_sym.sect != EDM_PAY |=> rx_bits.nbits == 2'h1 && rx_bits.bits[2:1] == 2'h0)
      else $error("non-payload symbol did not yield one bit");
endmodule
`default_nettype wire

// ==== edm_mapper.sv ====
// Symbol mapper for basic and enhanced rate packets, with receive demapper
`timescale 1ns/1ps
`default_nettype none
// Function
// - One symbol per microsecond, slot strobe every 625 symbols, in every mode.
// - Basic-rate symbols carry exactly one bit.
// - Enhanced payload carries two or three bits per symbol; other parts one.
// - Packet parts follow access, header, guard, sync, payload, trailer order.
// - Two-bit mode steps phase by plus or minus 45 or 135 degrees only.
// - Two-bit pairs 00,01,11,10 map to +45,+135,-135,-45; demap inverts.
// - Three-bit mode may step phase by any multiple of 45 degrees.
// - Gray triplets map to 0 through -45 degrees; demap inverts.
// - Basic rate sends one frequency-keyed bit per symbol, used outside payload.
module edm_mapper
   import edm_pkg::*;
(
   input  wire logic          clk_sys,  // System clock, 250 MHz
   input  wire logic          nrst,     // Synchronous reset, active low
   input  wire edm_tx_req_t   tx_req,   // Bits and packet part from baseband
   output logic               tx_ready, // Symbol boundary strobe; a valid request is taken this cycle
   output logic               sym_tick, // Symbol boundary strobe
   output logic               slot_tick,// Slot boundary strobe
   output var  edm_tx_sym_t   tx_sym,   // Symbol to the front end, registered
   output logic               seq_err,  // Packet part out of order, registered
   input  wire edm_rx_sym_t   rx_sym,   // Received symbol from the front end
   output var  edm_rx_bits_t  rx_bits   // Demapped bits to baseband
);
   import edm_pkg::*;

   logic [EDM_CYC_W-1:0]  cyc_r;
   logic [EDM_CYC_W-1:0]  cyc_nxt;
   logic [EDM_SLOT_W-1:0] slot_r;
   logic [EDM_SLOT_W-1:0] slot_nxt;
   edm_sect_t             sect_r;
   edm_rate_t             rate_r;
   logic                  seq_err_r;
   logic                  seq_err_nxt;
   logic                  in_pkt_r;
   edm_tx_sym_t           sym_nxt;

   // Symbol and slot timing
   wire logic cyc_end_w  = (cyc_r == EDM_CYC_W'(EDM_SYM_CYC - 1));
   wire logic slot_end_w = (slot_r == EDM_SLOT_W'(EDM_SLOT_SYM - 1));
   assign cyc_nxt   = cyc_end_w ? EDM_CYC_RST : cyc_r + 8'h01;
   assign slot_nxt  = !cyc_end_w ? slot_r : (slot_end_w ? EDM_SLOT_RST : slot_r + 10'h001);
   assign sym_tick  = cyc_end_w;
   assign slot_tick = cyc_end_w && slot_end_w;

   // A request is taken only on the symbol boundary
   wire logic take_w = tx_req.valid && cyc_end_w;
   assign tx_ready = cyc_end_w;

   // Payload rate is held from the last non-payload symbol
   wire edm_rate_t rate_use_w = (tx_req.sect == EDM_PAY) ? rate_r : tx_req.rate;
   wire logic [1:0] nb_w      = edm_nbits(tx_req.sect, rate_use_w);
   wire logic [2:0] dph_w     = edm_map(nb_w, tx_req.bits);

   // Part order: enhanced packets step one part at a time, basic skip guard, sync and trailer
   wire logic first_w  = (tx_req.sect == EDM_ACC);
   wire logic same_w   = in_pkt_r && (tx_req.sect == sect_r);
   wire logic step_w   = in_pkt_r && (tx_req.sect == edm_sect_t'(sect_r + 3'h1));
   wire logic br_jmp_w = in_pkt_r && (rate_r == EDM_BR) && (sect_r == EDM_HDR) && (tx_req.sect == EDM_PAY);
   wire logic br_bad_w = (rate_r == EDM_BR) && (tx_req.sect == EDM_GRD || tx_req.sect == EDM_SYN
                                                || tx_req.sect == EDM_TRL);
   wire logic order_ok_w = first_w || ((same_w || step_w || br_jmp_w) && !br_bad_w);

   always_comb begin
      seq_err_nxt = seq_err_r;
      if (take_w && first_w) begin
         seq_err_nxt = 1'b0;
      end
      if (take_w && !order_ok_w) begin
         seq_err_nxt = 1'b1;
      end
   end
   assign seq_err = seq_err_r;

   always_comb begin
      sym_nxt = tx_sym;
      if (cyc_end_w) begin
         sym_nxt.valid = take_w;
      end
      if (take_w) begin
         sym_nxt.nbits   = nb_w;
         sym_nxt.psk     = (nb_w != 2'h1);
         sym_nxt.fsk_bit = (nb_w == 2'h1) ? tx_req.bits[0] : 1'b0;
         sym_nxt.dphase  = dph_w;
         sym_nxt.phase   = tx_sym.phase + dph_w;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         cyc_r <= EDM_CYC_RST;
         slot_r <= EDM_SLOT_RST;
      end else begin
         cyc_r <= cyc_nxt;
         slot_r <= slot_nxt;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         sect_r    <= EDM_ACC;
         rate_r    <= EDM_BR;
         in_pkt_r  <= 1'b0;
         seq_err_r <= 1'b0;
      end else begin
         seq_err_r <= seq_err_nxt;
         if (take_w) begin
            sect_r   <= tx_req.sect;
            in_pkt_r <= (tx_req.sect != EDM_TRL);
            if (tx_req.sect != EDM_PAY) begin
               rate_r <= tx_req.rate;
            end
         end
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         tx_sym       <= '0;
         tx_sym.phase <= EDM_PHASE_RST;
      end else begin
         tx_sym <= sym_nxt;
      end
   end

   edm_demap u_demap (
      .clk_sys (clk_sys),
      .nrst    (nrst),
      .rx_sym  (rx_sym),
      .rx_bits (rx_bits)
   );

   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!nrst);

   sequence s_take_two;
      take_w && nb_w == 2'h2;
   endsequence
   sequence s_take_three;
      take_w && nb_w == 2'h3;
   endsequence

   chk_sym_period: assert property (sym_tick |-> ##250 sym_tick)
      else $error("symbol strobe period is not 250 cycles");
   chk_slot_on_sym: assert property (slot_tick |-> sym_tick && slot_r == 10'h270)
      else $error("slot strobe off its 625th symbol");
   chk_one_bit_outside: assert property (take_w && tx_req.sect != EDM_PAY
      |=> tx_sym.valid && !tx_sym.psk && tx_sym.nbits == 2'h1 && tx_sym.phase == $past(tx_sym.phase))
      else $error("non-payload symbol not sent as one keyed bit");
   chk_br_payload: assert property (take_w && rate_r == EDM_BR && tx_req.sect == EDM_PAY
      |=> !tx_sym.psk && tx_sym.fsk_bit == $past(tx_req.bits[0]))
      else $error("basic-rate payload symbol not one bit");
   chk_two_bit_step: assert property (s_take_two |=> tx_sym.psk && tx_sym.dphase[0]
      && tx_sym.nbits == 2'h2)
      else $error("two-bit phase step not an odd multiple of 45 degrees");
   chk_two_bit_map: assert property (s_take_two and tx_req.bits[1:0] == 2'h3
      |=> tx_sym.dphase == 3'h5)
      else $error("pair 11 not mapped to -135 degrees");
   chk_three_bit_map: assert property (s_take_three and tx_req.bits == 3'h6
      |=> tx_sym.dphase == 3'h4 && tx_sym.psk)
      else $error("triplet 110 not mapped to +180 degrees");
   chk_three_bit_zero: assert property (s_take_three and tx_req.bits == 3'h0
      |=> tx_sym.dphase == 3'h0 && tx_sym.phase == $past(tx_sym.phase))
      else $error("triplet 000 moved the phase");
   chk_phase_accum: assert property (take_w ##1 tx_sym.psk
      |-> tx_sym.phase == 3'($past(tx_sym.phase) + tx_sym.dphase))
      else $error("absolute phase does not follow the phase change");
   chk_sym_hold: assert property (tx_sym.valid && !sym_tick |=> $stable(tx_sym))
      else $error("symbol output changed inside a symbol period");
   chk_order_flag: assert property (take_w && !order_ok_w |=> seq_err)
      else $error("out-of-order packet part not flagged");

   // Timing counters never leave their ranges
   chk_cyc_range: assert property (cyc_r <= EDM_CYC_W'(EDM_SYM_CYC - 1))
      else $error("symbol cycle counter out of range");
   chk_slot_range: assert property (slot_r <= EDM_SLOT_W'(EDM_SLOT_SYM - 1))
      else $error("slot symbol counter out of range");
   chk_ready_tick: assert property (tx_ready == sym_tick)
      else $error("ready strobe off the symbol boundary");
   chk_idle_drop: assert property (sym_tick && !tx_req.valid |=> !tx_sym.valid)
      else $error("symbol stayed valid with no request at the boundary");

   // Payload of an enhanced packet must be phase keyed
   sequence s_take_pay;
      take_w && tx_req.sect == EDM_PAY;
   endsequence
   chk_pay_psk: assert property (s_take_pay and rate_r != EDM_BR |=> tx_sym.psk)
      else $error("enhanced payload symbol not phase keyed");
   chk_pay_rate_hold: assert property (s_take_pay |=> rate_r == $past(rate_r))
      else $error("payload symbol changed the held rate");

   // Further mapping corners
   chk_two_bit_zero: assert property (s_take_two and tx_req.bits[1:0] == 2'h0
      |=> tx_sym.dphase == 3'h1)
      else $error("pair 00 not mapped to +45 degrees");
   chk_three_bit_neg: assert property (s_take_three and tx_req.bits == 3'h7
      |=> tx_sym.dphase == 3'h5)
      else $error("triplet 111 not mapped to -135 degrees");
   chk_three_bit_quarter: assert property (s_take_three and tx_req.bits == 3'h3
      |=> tx_sym.dphase == 3'h2)
      else $error("triplet 011 not mapped to +90 degrees");

   // Error flag clears only on a new access code and otherwise holds
   chk_err_clear: assert property (take_w && first_w |=> !seq_err)
      else $error("access code did not clear the order flag");
   chk_err_hold: assert property (!take_w |=> seq_err == $past(seq_err))
      else $error("order flag changed with no symbol taken");
   chk_err_keep: assert property (take_w && !first_w && seq_err |=> seq_err)
      else $error("order flag cleared by a part other than access code");
endmodule
`default_nettype wire

// ==== edm_fe_model.sv ====
// Front-end model: hands each sent symbol back as a received phase change
`timescale 1ns/1ps
`default_nettype none
module edm_fe_model
   import edm_pkg::*;
(
   input  wire logic        clk_sys,  // System clock
   input  wire logic        nrst,     // Synchronous reset, active low
   input  wire logic        sym_tick, // Symbol boundary strobe
   input  wire edm_tx_req_t tx_req,   // Request seen by the mapper
   input  wire edm_tx_sym_t tx_sym,   // Symbol from the mapper
   output var  edm_rx_sym_t rx_sym    // Symbol handed back
);
   import edm_pkg::*;
   logic       tk_r;
   logic [2:0] ph_r;
   edm_sect_t  sect_r;
   edm_rate_t  rate_r;
   initial rx_sym = '0;
   always @(posedge clk_sys) begin
      if (!nrst) begin
         tk_r <= 1'b0;
         ph_r <= 3'h0;
         sect_r <= EDM_ACC;
         rate_r <= EDM_BR;
         rx_sym <= '0;
      end else begin
         tk_r <= sym_tick;
         rx_sym.valid <= 1'b0;
         // Idle lines keep changing so stale values are never trusted
         rx_sym.dphase <= ~rx_sym.dphase;
         rx_sym.fsk_bit <= ~rx_sym.fsk_bit;
         if (sym_tick && tx_req.valid) begin
            sect_r <= tx_req.sect;
            if (tx_req.sect != EDM_PAY) rate_r <= tx_req.rate;
         end
         if (tk_r && tx_sym.valid) begin
            rx_sym.valid <= 1'b1;
            rx_sym.sect <= sect_r;
            rx_sym.rate <= rate_r;
            rx_sym.fsk_bit <= tx_sym.fsk_bit;
            rx_sym.dphase <= tx_sym.phase - ph_r;
            ph_r <= tx_sym.phase;
         end
      end
   end
endmodule
`default_nettype wire

// ==== edr_differential_phase_mapper_test.sv ====
// Self-checking testbench for the phase mapper with a looped-back front end
`timescale 1ns/1ps
`default_nettype none
module edr_differential_phase_mapper_test;
   import edm_pkg::*;
   localparam logic [2:0] MAP2 [4] = '{3'h1, 3'h3, 3'h7, 3'h5};
   localparam logic [2:0] MAP3 [8] = '{3'h0, 3'h1, 3'h3, 3'h2, 3'h7, 3'h6, 3'h4, 3'h5};
   localparam edm_rate_t RT [3] = '{EDM_R2, EDM_R3, EDM_BR};
   localparam edm_sect_t ES [8] = '{EDM_HDR, EDM_ACC, EDM_HDR, EDM_GRD, EDM_ACC, EDM_HDR, EDM_TRL, EDM_ACC};
   localparam logic [7:0] EE = 8'h49;
   logic         clk_sys;
   logic         nrst;
   edm_tx_req_t  tx_req;
   logic         tx_ready;
   logic         sym_tick;
   logic         slot_tick;
   edm_tx_sym_t  tx_sym;
   logic         seq_err;
   edm_rx_sym_t  rx_sym;
   edm_rx_bits_t rx_bits;
   int           n_fail;
   int           n_tests;
   int           seed;
   int           cnt;
   int           nsym;
   logic         seen;
   logic         tk_prev;
   logic [2:0]   ph;
   edm_rate_t    lr;
   logic [10:0]  q_tx[$];
   logic [5:0]   q_rx[$];

   edm_mapper dut (.clk_sys(clk_sys), .nrst(nrst), .tx_req(tx_req), .tx_ready(tx_ready), .sym_tick(sym_tick),
      .slot_tick(slot_tick), .tx_sym(tx_sym), .seq_err(seq_err), .rx_sym(rx_sym), .rx_bits(rx_bits));
   edm_fe_model fe (.clk_sys(clk_sys), .nrst(nrst), .sym_tick(sym_tick), .tx_req(tx_req), .tx_sym(tx_sym),
      .rx_sym(rx_sym));

   task automatic results;
      $display("tests %0d failures %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         n_fail++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Notes the expected symbol, shows junk first, then holds the request until a tick takes it
   task automatic send(input edm_sect_t s, input edm_rate_t r, input logic [2:0] b, input logic e);
      logic [1:0] n;
      logic [2:0] d;
      int         i;
      if (s != EDM_PAY) lr = r;
      n = (s != EDM_PAY) ? 2'h1 : (lr == EDM_R2) ? 2'h2 : (lr == EDM_R3) ? 2'h3 : 2'h1;
      d = (n == 2'h2) ? MAP2[b[1:0]] : (n == 2'h3) ? MAP3[b] : 3'h0;
      ph = ph + d;
      q_tx.push_back({1'b1, n != 2'h1, n, d, ph, (n == 2'h1) ? b[0] : 1'b0});
      q_rx.push_back({1'b1, n, (n == 2'h3) ? b : (n == 2'h2) ? {1'b0, b[1:0]} : {2'h0, b[0]}});
      tx_req = edm_tx_req_t'({1'b1, 8'($random(seed))});
      repeat (5) @(posedge clk_sys);
      #1 tx_req = '{1'b1, s, r, b};
      for (i = 0; i < 300 && sym_tick !== 1'b1; i++) begin
         @(posedge clk_sys);
         #1;
      end
      if (i == 300) begin
         n_fail++;
         results();
      end
      @(posedge clk_sys);
      #1 chk(32'(seq_err), 32'(e));
   endtask

   initial begin
      clk_sys = 1'b0;
      forever #2 clk_sys = ~clk_sys;
   end

   initial begin
      repeat (100000) @(posedge clk_sys);
      n_fail++;
      results();
   end

   // Watcher: takes the oldest note off each queue whenever a result appears
   initial begin
      tk_prev = 1'b0;
      seen = 1'b0;
      cnt = 0;
      nsym = 0;
      forever begin
         @(posedge clk_sys);
         #2;
         cnt++;
         if (tk_prev && q_tx.size() > 0)
            chk(32'({tx_sym.valid, tx_sym.psk, tx_sym.nbits, tx_sym.dphase, tx_sym.phase,
               tx_sym.psk ? 1'b0 : tx_sym.fsk_bit}), 32'(q_tx.pop_front()));
         else if (tk_prev) chk(32'(tx_sym.valid), 32'h0);
         if (rx_bits.valid === 1'b1)
            chk(32'(rx_bits), (q_rx.size() > 0) ? 32'(q_rx.pop_front()) : 32'hffff);
         if (sym_tick === 1'b1) begin
            chk(32'(tx_ready), 32'h1);
            chk(32'(slot_tick), 32'(nsym % 625 == 624));
            nsym++;
            if (seen) chk(32'(cnt), 32'h00fa);
            seen = 1'b1;
            cnt = 0;
         end
         tk_prev = sym_tick;
      end
   end

   initial begin
      seed = 32'h0db6;
      n_fail = 0;
      n_tests = 0;
      ph = 3'h0;
      lr = EDM_BR;
      nrst = 1'b0;
      tx_req = '0;
      repeat (2) @(posedge clk_sys);
      #1 chk(32'({tx_sym, seq_err, rx_bits}), 32'h0);
      nrst = 1'b1;
      foreach (RT[k]) begin
         send(EDM_ACC, RT[k], 3'h0, 1'b0);
         send(EDM_HDR, RT[k], 3'h1, 1'b0);
         if (RT[k] != EDM_BR) begin
            send(EDM_GRD, RT[k], 3'h1, 1'b0);
            send(EDM_SYN, RT[k], 3'h0, 1'b0);
         end
         for (int i = 0; i < 12; i++) send(EDM_PAY, RT[k], (i < 8) ? 3'(i) : 3'($random(seed)), 1'b0);
         if (RT[k] != EDM_BR) send(EDM_TRL, RT[k], 3'h1, 1'b0);
      end
      // Out-of-order parts are still sent but flag an error until a new access code
      foreach (ES[k]) send(ES[k], (k < 4) ? EDM_BR : EDM_R2, 3'h1, EE[k]);
      tx_req = '0;
      for (int i = 0; i < 600 && (q_tx.size() > 0 || q_rx.size() > 0); i++) @(posedge clk_sys);
      if (q_tx.size() > 0 || q_rx.size() > 0) n_fail++;
      repeat (260) @(posedge clk_sys);
      results();
   end
endmodule
`default_nettype wire
